// ==== core/mhi_pkg.sv ====
// Shared constants, types and strap decoding for the MCU host interface
package mhi_pkg;

  // ****************************************************************
  // Interface modes and strap codes
  // ****************************************************************
  typedef enum logic [2:0] {
    MHI_MODE_OFF,
    MHI_MODE_SER,
    MHI_MODE_6800_4,
    MHI_MODE_6800_8,
    MHI_MODE_8080_4,
    MHI_MODE_8080_8
  } mhi_mode_t;

  localparam logic [2:0] MHI_STRAP_SER     = 3'h1;
  localparam logic [2:0] MHI_STRAP_6800_4  = 3'h2;
  localparam logic [2:0] MHI_STRAP_6800_8  = 3'h3;
  localparam logic [2:0] MHI_STRAP_8080_4  = 3'h4;
  localparam logic [2:0] MHI_STRAP_8080_8  = 3'h5;

  // ****************************************************************
  // Pin synchroniser layout
  // ****************************************************************
  localparam int            MHI_SYNC_W   = 14;
  localparam int            MHI_IX_E     = 0;
  localparam int            MHI_IX_RW    = 1;
  localparam int            MHI_IX_DC    = 2;
  localparam int            MHI_IX_CS    = 3;
  localparam int            MHI_IX_WT    = 4;
  localparam int            MHI_IX_RT    = 5;
  localparam int            MHI_IX_D     = 6;
  localparam logic [13:0]   MHI_SYNC_RST = 14'h0008;

  // ****************************************************************
  // Serial framing and reset values
  // ****************************************************************
  localparam logic [2:0] MHI_ONES_LAST  = 3'h4;
  localparam logic [3:0] MHI_WR_LAST    = 4'hF;
  localparam logic [7:0] MHI_OE_OFF     = 8'hFF;
  localparam logic [7:0] MHI_OE_HI_NIB  = 8'h0F;
  localparam logic [7:0] MHI_OE_ALL     = 8'h00;
  localparam logic [7:0] MHI_OE_SOD     = 8'hFB;
  localparam logic [7:0] MHI_BYTE_RST   = 8'h00;

  typedef enum logic [2:0] {
    MHI_SER_HUNT,
    MHI_SER_RW,
    MHI_SER_DC,
    MHI_SER_END,
    MHI_SER_WRITE,
    MHI_SER_READ
  } mhi_ser_st_t;

  function automatic mhi_mode_t mhi_decode(input logic [2:0] strap);
    mhi_mode_t m;
    m = MHI_MODE_OFF;
    unique case (strap)
      MHI_STRAP_SER:    m = MHI_MODE_SER;
      MHI_STRAP_6800_4: m = MHI_MODE_6800_4;
      MHI_STRAP_6800_8: m = MHI_MODE_6800_8;
      MHI_STRAP_8080_4: m = MHI_MODE_8080_4;
      MHI_STRAP_8080_8: m = MHI_MODE_8080_8;
      default:          m = MHI_MODE_OFF;
    endcase
    return m;
  endfunction

endpackage

// ==== core/mhi_ser_if.sv ====
// Link between the serial framer and the host port core
`timescale 1ns/1ps
interface mhi_ser_if;
  logic       wr_tgl;
  logic [7:0] wr_byte;
  logic       is_data;
  logic       rd_tgl;
  logic [7:0] rd_word;

  modport ser_end  (output wr_tgl, output wr_byte, output is_data, output rd_tgl, input rd_word);
  modport core_end (input wr_tgl, input wr_byte, input is_data, input rd_tgl, output rd_word);
endinterface

// ==== core/mhi_serial.sv ====
// Serial framer running on the host shift clock
`timescale 1ns/1ps
module mhi_serial
  import mhi_pkg::*;
(
  input  wire logic   serial_clock_i,
  input  wire logic   ser_rst_n_i,
  input  wire logic   ce_i,
  input  wire logic   serial_in_line_i,
  output logic        serial_out_line_o,
  mhi_ser_if.ser_end  lnk
);

  mhi_ser_st_t st_r, st_nxt;
  logic [2:0]  ones_r, ones_nxt;
  logic [3:0]  cnt_r, cnt_nxt;
  logic        rw_r, rw_nxt;
  logic        register_select_bit_r, register_select_bit_nxt;
  logic [7:0]  data_r, data_nxt;
  logic [7:0]  byte_r, byte_nxt;
  logic [7:0]  sh_r, sh_nxt;
  logic        wt_r, wt_nxt;
  logic        rt_r, rt_nxt;
  logic        sod_r, sod_nxt;
  logic        ce_s1_r, ce_s2_r;

  // ****************************************************************
  // Clock enable crossing
  // ****************************************************************
  always_ff @(posedge serial_clock_i or negedge ser_rst_n_i) begin
    if (!ser_rst_n_i) begin
      // Enabled at once, so the first bits after chip select falls are not lost
      ce_s1_r <= 1'b1;
      ce_s2_r <= 1'b1;
    end else begin
      ce_s1_r <= ce_i;
      ce_s2_r <= ce_s1_r;
    end
  end

  // ****************************************************************
  // Framing
  // ****************************************************************
  always_comb begin
    st_nxt                  = st_r;
    ones_nxt                = serial_in_line_i ? ones_r + 3'h1 : 3'h0;
    cnt_nxt                 = cnt_r;
    rw_nxt                  = rw_r;
    register_select_bit_nxt = register_select_bit_r;
    data_nxt                = data_r;
    byte_nxt                = byte_r;
    sh_nxt                  = sh_r;
    wt_nxt                  = wt_r;
    rt_nxt                  = rt_r;
    sod_nxt                 = sod_r;
    if (serial_in_line_i && ones_r == MHI_ONES_LAST) begin
      st_nxt   = MHI_SER_RW;
      ones_nxt = 3'h0;
      cnt_nxt  = 4'h0;
    end else begin
      unique case (st_r)
        MHI_SER_HUNT: begin
          st_nxt = MHI_SER_HUNT;
        end
        MHI_SER_RW: begin
          rw_nxt = serial_in_line_i;
          st_nxt = MHI_SER_DC;
        end
        MHI_SER_DC: begin
          register_select_bit_nxt = serial_in_line_i;
          st_nxt                  = MHI_SER_END;
        end
        MHI_SER_END: begin
          cnt_nxt = 4'h0;
          if (serial_in_line_i) begin
            st_nxt = MHI_SER_HUNT;
          end else begin
            st_nxt = rw_r ? MHI_SER_READ : MHI_SER_WRITE;
          end
        end
        MHI_SER_WRITE: begin
          cnt_nxt = cnt_r + 4'h1;
          if (!cnt_r[2]) begin
            data_nxt[{cnt_r[3], cnt_r[1:0]}] = serial_in_line_i;
          end
          if (cnt_r == MHI_WR_LAST) begin
            byte_nxt = data_r;
            wt_nxt   = ~wt_r;
          end
        end
        MHI_SER_READ: begin
          cnt_nxt = {1'b0, cnt_r[2:0] + 3'h1};
          if (cnt_r[2:0] == 3'h0) begin
            sh_nxt  = lnk.rd_word;
            sod_nxt = lnk.rd_word[0];
            rt_nxt  = ~rt_r;
          end else begin
            sod_nxt = sh_r[cnt_r[2:0]];
          end
        end
      endcase
    end
  end

  // Chip select high holds everything here in reset
  always_ff @(posedge serial_clock_i or negedge ser_rst_n_i) begin
    if (!ser_rst_n_i) begin
      st_r                  <= MHI_SER_HUNT;
      ones_r                <= 3'h0;
      cnt_r                 <= 4'h0;
      rw_r                  <= 1'b0;
      register_select_bit_r <= 1'b0;
      data_r                <= MHI_BYTE_RST;
      byte_r                <= MHI_BYTE_RST;
      sh_r                  <= MHI_BYTE_RST;
      wt_r                  <= 1'b0;
      rt_r                  <= 1'b0;
      sod_r                 <= 1'b0;
    end else if (ce_s2_r) begin
      st_r                  <= st_nxt;
      ones_r                <= ones_nxt;
      cnt_r                 <= cnt_nxt;
      rw_r                  <= rw_nxt;
      register_select_bit_r <= register_select_bit_nxt;
      data_r                <= data_nxt;
      byte_r                <= byte_nxt;
      sh_r                  <= sh_nxt;
      wt_r                  <= wt_nxt;
      rt_r                  <= rt_nxt;
      sod_r                 <= sod_nxt;
    end
  end

  assign lnk.wr_tgl         = wt_r;
  assign lnk.wr_byte        = byte_r;
  assign lnk.is_data        = register_select_bit_r;
  assign lnk.rd_tgl         = rt_r;
  assign serial_out_line_o  = sod_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  sequence s_fifth_one;
    ce_s2_r && serial_in_line_i && ones_r == 3'h4;
  endsequence

  five_ones_a: assert property (@(posedge serial_clock_i) disable iff (!ser_rst_n_i)
    s_fifth_one |=> st_r == MHI_SER_RW && cnt_r == 4'h0)
    else $error("five ones did not restart framing");

  end_bit_a: assert property (@(posedge serial_clock_i) disable iff (!ser_rst_n_i)
    ce_s2_r && st_r == MHI_SER_END && !serial_in_line_i && ones_r != 3'h4
      |=> st_r == ($past(rw_r) ? MHI_SER_READ : MHI_SER_WRITE))
    else $error("end bit did not open the transfer");

  write_byte_a: assert property (@(posedge serial_clock_i) disable iff (!ser_rst_n_i)
    ce_s2_r && st_r == MHI_SER_WRITE && cnt_r == 4'hF && !(serial_in_line_i && ones_r == 3'h4)
      |=> wt_r != $past(wt_r) && byte_r == $past(data_r) && st_r == MHI_SER_WRITE)
    else $error("serial write byte not delivered");

  read_shift_a: assert property (@(posedge serial_clock_i) disable iff (!ser_rst_n_i)
    ce_s2_r && st_r == MHI_SER_READ && cnt_r == 4'h0 && !serial_in_line_i
      |=> sod_r == $past(lnk.rd_word[0]) && rt_r != $past(rt_r))
    else $error("serial read did not start with the low bit");

endmodule

// ==== core/mhi_host_port.sv ====
// MCU host port: strap mode select, 6800/8080 parallel access and serial link
`timescale 1ns/1ps
// Overview of operation
// - Interface mode comes from the three strap pins, captured once after reset.
// - Command/data select low means command access, high means display data access.
// - In 6800 mode direction low means write, high means read.
// - 6800 transfers complete on the enable falling edge, only with chip select low.
// - 8080 read completes on the read strobe rising edge with chip select low.
// - 8080 write latches on the write strobe rising edge with chip select low.
// - Data reads are pipelined; the first read after addressing returns stale content.
// - 4-bit mode moves each byte as two transfers on the upper data lines.
// - In 4-bit mode the upper nibble goes first, then the lower nibble.
// - 8-bit mode moves each byte in one transfer on all eight lines.
// - Serial mode: shift clock on its own serial_clock_i pin, line 1 data in, line 2 data out.
// - Serial clocks count only with chip select low; high resets the bit counter.
// - Five consecutive ones on serial input restart framing for a new start byte.
// - Start byte: select picks command/data, direction picks read/write, end bit zero.
// - A frame sync output lets the host time writes against scanning.
// - Serial write byte is sent as two nibbles, low first, each with four zeros.
// - Following serial bytes with unchanged direction and select need no new start byte.
// - Serial read shifts out eight bits, least significant first, after a host wait.
module mhi_host_port
  import mhi_pkg::*;
(
  input  wire logic        clock_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  input  wire logic        serial_clock_i,
  input  wire logic [2:0]  interface_strap_pins_i,
  input  wire logic        cs_n_i,
  input  wire logic        dc_i,
  input  wire logic        rw_wr_i,
  input  wire logic        e_rd_i,
  input  wire logic [7:0]  d_i,
  output logic      [7:0]  d_o_o,
  output logic      [7:0]  d_oe_n_o,
  output logic             wr_stb_o,
  output logic      [7:0]  wr_byte_o,
  output logic             wr_is_data_o,
  output logic             mem_rd_o,
  input  wire logic [7:0]  mem_rd_data_i,
  input  wire logic [7:0]  status_i,
  input  wire logic        frame_sync_i,
  output logic             tearing_sync_output_o
);

  mhi_ser_if lnk ();

  logic [MHI_SYNC_W-1:0][2:0] sync_r;
  logic [MHI_SYNC_W-1:0]      pin_vec;
  logic [MHI_SYNC_W-1:0]      filt_r, filt_nxt;
  logic [MHI_SYNC_W-1:0]      prev_r, prev_nxt;
  mhi_mode_t                  mode_r, mode_nxt;
  logic                       mode_vld_r, mode_vld_nxt;
  logic                       nib_r, nib_nxt;
  logic [3:0]                 hold_r, hold_nxt;
  logic [7:0]                 latch_r, latch_nxt;
  logic                       wr_stb_r, wr_stb_nxt;
  logic [7:0]                 wr_byte_r, wr_byte_nxt;
  logic                       wr_dc_r, wr_dc_nxt;
  logic                       mem_rd_r, mem_rd_nxt;
  logic [7:0]                 d_r, d_nxt;
  logic [7:0]                 oe_n_r, oe_n_nxt;
  logic [7:0]                 word_r, word_nxt;
  logic                       tsync_r, tsync_nxt;
  logic                       serial_out_line;
  logic                       ser_rst_n;
  logic                       m6800, m8080, four, ser;
  logic                       wr_acc, rd_acc, rd_active;
  logic                       wt_evt, rt_evt, lnk_ok;
  logic [7:0]                 d_f, rv;

  // ****************************************************************
  // Pin synchronisers with agreement filter
  // ****************************************************************
  assign pin_vec = {d_i, lnk.rd_tgl, lnk.wr_tgl, cs_n_i, dc_i, rw_wr_i, e_rd_i};

  for (genvar g = 0; g < MHI_SYNC_W; g++) begin : g_sync
    always_comb begin
      filt_nxt[g] = (sync_r[g][1] == sync_r[g][2]) ? sync_r[g][2] : filt_r[g];
    end
    always_ff @(posedge clock_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        sync_r[g] <= {3{MHI_SYNC_RST[g]}};
        filt_r[g] <= MHI_SYNC_RST[g];
      end else if (ce_i) begin
        sync_r[g] <= {sync_r[g][1:0], pin_vec[g]};
        filt_r[g] <= filt_nxt[g];
      end
    end
  end

  // ****************************************************************
  // Access decode
  // ****************************************************************
  always_comb begin
    m6800     = (mode_r == MHI_MODE_6800_4) || (mode_r == MHI_MODE_6800_8);
    m8080     = (mode_r == MHI_MODE_8080_4) || (mode_r == MHI_MODE_8080_8);
    four      = (mode_r == MHI_MODE_6800_4) || (mode_r == MHI_MODE_8080_4);
    ser       = (mode_r == MHI_MODE_SER);
    d_f       = filt_r[MHI_IX_D +: 8];
    wr_acc    = !filt_r[MHI_IX_CS] &&
                ((m6800 && prev_r[MHI_IX_E] && !filt_r[MHI_IX_E] && !filt_r[MHI_IX_RW]) ||
                 (m8080 && !prev_r[MHI_IX_RW] && filt_r[MHI_IX_RW]));
    rd_acc    = !filt_r[MHI_IX_CS] &&
                ((m6800 && prev_r[MHI_IX_E] && !filt_r[MHI_IX_E] && filt_r[MHI_IX_RW]) ||
                 (m8080 && !prev_r[MHI_IX_E] && filt_r[MHI_IX_E]));
    rd_active = !filt_r[MHI_IX_CS] &&
                ((m6800 && filt_r[MHI_IX_E] && filt_r[MHI_IX_RW]) ||
                 (m8080 && !filt_r[MHI_IX_E]));
    // Chip select high resets the link toggles; that change is not a byte
    lnk_ok    = ser && !filt_r[MHI_IX_CS] && !sync_r[MHI_IX_CS][1];
    wt_evt    = lnk_ok && (filt_r[MHI_IX_WT] != prev_r[MHI_IX_WT]);
    rt_evt    = lnk_ok && (filt_r[MHI_IX_RT] != prev_r[MHI_IX_RT]);
    rv        = filt_r[MHI_IX_DC] ? latch_r : status_i;
  end

  // ****************************************************************
  // Transfer engine
  // ****************************************************************
  always_comb begin
    mode_nxt     = mode_r;
    mode_vld_nxt = 1'b1;
    prev_nxt     = filt_r;
    nib_nxt      = nib_r;
    hold_nxt     = hold_r;
    latch_nxt    = latch_r;
    wr_stb_nxt   = 1'b0;
    wr_byte_nxt  = wr_byte_r;
    wr_dc_nxt    = wr_dc_r;
    mem_rd_nxt   = 1'b0;
    if (!mode_vld_r) begin
      mode_nxt = mhi_decode(interface_strap_pins_i);
    end
    if (filt_r[MHI_IX_CS]) begin
      nib_nxt = 1'b0;
    end
    if (wr_acc) begin
      if (four && !nib_r) begin
        hold_nxt = d_f[7:4];
        nib_nxt  = 1'b1;
      end else begin
        wr_stb_nxt  = 1'b1;
        wr_byte_nxt = four ? {hold_r, d_f[7:4]} : d_f;
        wr_dc_nxt   = filt_r[MHI_IX_DC];
        nib_nxt     = 1'b0;
      end
    end
    if (rd_acc) begin
      if (four && !nib_r) begin
        nib_nxt = 1'b1;
      end else begin
        nib_nxt = 1'b0;
        if (filt_r[MHI_IX_DC]) begin
          latch_nxt  = mem_rd_data_i;
          mem_rd_nxt = 1'b1;
        end
      end
    end
    if (wt_evt) begin
      wr_stb_nxt  = 1'b1;
      wr_byte_nxt = lnk.wr_byte;
      wr_dc_nxt   = lnk.is_data;
    end
    if (rt_evt && lnk.is_data) begin
      latch_nxt  = mem_rd_data_i;
      mem_rd_nxt = 1'b1;
    end
    word_nxt = lnk.is_data ? latch_r : status_i;
    if (four) begin
      d_nxt = {nib_r ? rv[3:0] : rv[7:4], 4'h0};
    end else begin
      d_nxt = rv;
    end
    if (ser) begin
      oe_n_nxt = filt_r[MHI_IX_CS] ? MHI_OE_OFF : MHI_OE_SOD;
    end else if (rd_active) begin
      oe_n_nxt = four ? MHI_OE_HI_NIB : MHI_OE_ALL;
    end else begin
      oe_n_nxt = MHI_OE_OFF;
    end
    tsync_nxt = frame_sync_i;
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      mode_r     <= MHI_MODE_OFF;
      mode_vld_r <= 1'b0;
      prev_r     <= MHI_SYNC_RST;
      nib_r      <= 1'b0;
      hold_r     <= 4'h0;
      latch_r    <= MHI_BYTE_RST;
      wr_stb_r   <= 1'b0;
      wr_byte_r  <= MHI_BYTE_RST;
      wr_dc_r    <= 1'b0;
      mem_rd_r   <= 1'b0;
      d_r        <= MHI_BYTE_RST;
      oe_n_r     <= MHI_OE_OFF;
      word_r     <= MHI_BYTE_RST;
      tsync_r    <= 1'b0;
    end else if (ce_i) begin
      mode_r     <= mode_nxt;
      mode_vld_r <= mode_vld_nxt;
      prev_r     <= prev_nxt;
      nib_r      <= nib_nxt;
      hold_r     <= hold_nxt;
      latch_r    <= latch_nxt;
      wr_stb_r   <= wr_stb_nxt;
      wr_byte_r  <= wr_byte_nxt;
      wr_dc_r    <= wr_dc_nxt;
      mem_rd_r   <= mem_rd_nxt;
      d_r        <= d_nxt;
      oe_n_r     <= oe_n_nxt;
      word_r     <= word_nxt;
      tsync_r    <= tsync_nxt;
    end
  end

  // ****************************************************************
  // Serial framer on the shift clock
  // ****************************************************************
  assign ser_rst_n   = rst_n_i & ~cs_n_i;
  assign lnk.rd_word = word_r;

  mhi_serial u_serial (
    .serial_clock_i    (serial_clock_i),
    .ser_rst_n_i       (ser_rst_n),
    .ce_i              (ce_i),
    .serial_in_line_i  (d_i[1]),
    .serial_out_line_o (serial_out_line),
    .lnk               (lnk)
  );

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign d_o_o                 = ser ? {d_r[7:3], serial_out_line, d_r[1:0]} : d_r;
  assign d_oe_n_o              = oe_n_r;
  assign wr_stb_o              = wr_stb_r;
  assign wr_byte_o             = wr_byte_r;
  assign wr_is_data_o          = wr_dc_r;
  assign mem_rd_o              = mem_rd_r;
  assign tearing_sync_output_o = tsync_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_e_fall_wr8;
    ce_i && m6800 && !four && prev_r[MHI_IX_E] && !filt_r[MHI_IX_E] &&
      !filt_r[MHI_IX_CS] && !filt_r[MHI_IX_RW];
  endsequence

  sequence s_rd_rise_data8;
    ce_i && m8080 && !four && !prev_r[MHI_IX_E] && filt_r[MHI_IX_E] &&
      !filt_r[MHI_IX_CS] && filt_r[MHI_IX_DC];
  endsequence

  strap_lock_a: assert property (mode_vld_r |=> mode_r == $past(mode_r))
    else $error("interface mode changed after capture");

  write_select_a: assert property (
    ce_i && wr_acc && !(four && !nib_r) && !wt_evt
      |=> wr_stb_o && wr_is_data_o == $past(filt_r[MHI_IX_DC]))
    else $error("write select not carried to the strobe");

  e_fall_write_a: assert property (s_e_fall_wr8 |=> wr_stb_o && wr_byte_o == $past(d_f))
    else $error("6800 write not latched on enable fall");

  no_select_a: assert property (
    ce_i && filt_r[MHI_IX_CS] && !ser |=> !wr_stb_o && !mem_rd_o)
    else $error("transfer taken without chip select");

  read_advance_a: assert property (
    s_rd_rise_data8 |=> mem_rd_o && latch_r == $past(mem_rd_data_i))
    else $error("8080 data read did not advance the pipeline");

  wr_rise_a: assert property (
    ce_i && m8080 && !four && !prev_r[MHI_IX_RW] && filt_r[MHI_IX_RW] && !filt_r[MHI_IX_CS]
      |=> wr_stb_o ##1 !wr_stb_o || !ce_i)
    else $error("8080 write not latched on strobe rise");

  first_nibble_a: assert property (
    ce_i && four && wr_acc && !nib_r |=> !wr_stb_o && nib_r)
    else $error("first nibble produced a byte");

  nibble_pair_a: assert property (
    ce_i && four && wr_acc && nib_r
      |=> wr_stb_o && wr_byte_o == {$past(hold_r), $past(d_f[7:4])})
    else $error("nibble order wrong");

  status_read_a: assert property (
    ce_i && rd_active && !filt_r[MHI_IX_DC] && !four
      |=> d_o_o == $past(status_i) && d_oe_n_o == 8'h00)
    else $error("command read did not return status");

  tear_sync_a: assert property (ce_i |=> tearing_sync_output_o == $past(frame_sync_i))
    else $error("frame sync output not following");

endmodule

// ==== tb/mhi_mcu_model.sv ====
// Host microcontroller model driving the parallel and serial pins
`timescale 1ns/1ps
module mhi_mcu_model (
  input  wire logic       clk_i,
  input  wire logic       m6800_i,
  input  wire logic       nib4_i,
  output logic            cs_n_o,
  output logic            dc_o,
  output logic            rw_wr_o,
  output logic            e_rd_o,
  output logic [7:0]      d_o,
  output logic            sclk_o,
  input  wire logic [7:0] dev_d_i
);
  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  initial begin
    cs_n_o = 1'h1;
    dc_o = 1'h0;
    rw_wr_o = 1'h1;
    e_rd_o = 1'h1;
    d_o = 8'h00;
    sclk_o = 1'h0;
  end

  // One strobe phase; a read drives the data lines with the inverse of their last value
  task automatic xfer(input logic rd, input logic dc, input logic [7:0] wd,
                      output logic [7:0] rv);
    @(negedge clk_i);
    dc_o = dc;
    if (m6800_i) rw_wr_o = rd;
    d_o = rd ? ~d_o : wd;
    repeat (8) @(negedge clk_i);
    if (m6800_i) e_rd_o = 1'h1;
    else if (rd) e_rd_o = 1'h0;
    else rw_wr_o = 1'h0;
    repeat (8) @(negedge clk_i);
    rv = dev_d_i;
    if (m6800_i) e_rd_o = 1'h0;
    else begin
      e_rd_o = 1'h1;
      rw_wr_o = 1'h1;
    end
    repeat (8) @(negedge clk_i);
  endtask

  task automatic byte_op(input logic sel, input logic rd, input logic dc,
                         input logic [7:0] wd, output logic [7:0] rv);
    logic [7:0] h;
    e_rd_o = ~m6800_i;
    rw_wr_o = 1'h1;
    @(negedge clk_i);
    cs_n_o = ~sel;
    if (nib4_i) begin
      xfer(rd, dc, {wd[7:4], 4'h0}, h);
      xfer(rd, dc, {wd[3:0], 4'h0}, rv);
      rv = {h[7:4], rv[7:4]};
    end else xfer(rd, dc, wd, rv);
    cs_n_o = 1'h1;
  endtask

  // Serial bits go out first bit first; the shift clock idles low
  task automatic ser_send(input logic [15:0] bits, input int n);
    cs_n_o = 1'h0;
    d_o = 8'h00;
    #43;
    for (int i = 0; i < n; i++) begin
      d_o[1] = bits[i];
      #15 sclk_o = 1'h1;
      #15 sclk_o = 1'h0;
    end
  endtask

  // Read clocks keep the serial input low so no start byte is seen
  task automatic ser_read(output logic [7:0] v);
    for (int i = 0; i < 8; i++) begin
      d_o[1] = 1'h0;
      #15 sclk_o = 1'h1;
      #15 sclk_o = 1'h0;
      v[i] = dev_d_i[2];
    end
  endtask
endmodule

// ==== tb/tb_top.sv ====
// Self-checking bench for the MCU host port
`timescale 1ns/1ps
module tb_top;
  import mhi_pkg::*;
  logic       clock_i, rst_n_i, sclk, cs_n, dc, rw_wr, e_rd, fsync, tso, m6800, nib4, ce;
  logic       wr_stb, is_data, mem_rd;
  logic [2:0] strap;
  logic [7:0] d, d_o, d_oe_n, wr_byte, addr, rv;
  int         n_fail, total_checks, n_wr;
  logic [2:0] straps [4] = '{MHI_STRAP_8080_8, MHI_STRAP_6800_8, MHI_STRAP_8080_4,
                             MHI_STRAP_6800_4};

  mhi_host_port dut (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(ce),
    .serial_clock_i(sclk), .interface_strap_pins_i(strap), .cs_n_i(cs_n), .dc_i(dc),
    .rw_wr_i(rw_wr), .e_rd_i(e_rd), .d_i(d), .d_o_o(d_o), .d_oe_n_o(d_oe_n),
    .wr_stb_o(wr_stb), .wr_byte_o(wr_byte), .wr_is_data_o(is_data), .mem_rd_o(mem_rd),
    .mem_rd_data_i(8'h40 + addr), .status_i(8'hA5), .frame_sync_i(fsync),
    .tearing_sync_output_o(tso));
  mhi_mcu_model mcu (.clk_i(clock_i), .m6800_i(m6800), .nib4_i(nib4), .cs_n_o(cs_n),
    .dc_o(dc), .rw_wr_o(rw_wr), .e_rd_o(e_rd), .d_o(d), .sclk_o(sclk), .dev_d_i(d_o));

  // ****************************************************************
  // Clock, memory stand-in and helpers
  // ****************************************************************
  initial begin
    clock_i = 1'h0;
    forever #5 clock_i = ~clock_i;
  end

  always @(posedge clock_i) begin
    if (mem_rd === 1'h1) addr <= addr + 8'h01;
    if (wr_stb === 1'h1) n_wr++;
  end

  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic do_reset(input logic [2:0] s);
    @(negedge clock_i);
    rst_n_i = 1'h0;
    strap = s;
    m6800 = (s == MHI_STRAP_6800_4) || (s == MHI_STRAP_6800_8);
    nib4 = (s == MHI_STRAP_6800_4) || (s == MHI_STRAP_8080_4);
    addr = 8'h00;
    n_wr = 0;
    repeat (6) @(negedge clock_i);
    rst_n_i = 1'h1;
    repeat (4) @(negedge clock_i);
  endtask

  task automatic print_verdict;
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  initial begin
    #300000;
    n_fail++;
    print_verdict;
  end

  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    rst_n_i = 1'h0;
    strap = 3'h0;
    fsync = 1'h0;
    ce = 1'h1;
    addr = 8'h00;
    foreach (straps[i]) begin
      do_reset(straps[i]);
      mcu.byte_op(1'h1, 1'h0, 1'h1, 8'h8D, rv);
      mcu.byte_op(1'h0, 1'h0, 1'h0, 8'h77, rv);
      chk("wr_count", 8'(n_wr), 8'h01);
      chk("wr_byte", wr_byte, 8'h8D);
      chk("wr_is_data", {7'h0, is_data}, 8'h01);
      mcu.byte_op(1'h1, 1'h1, 1'h1, 8'h00, rv);
      chk("dummy_read", rv, MHI_BYTE_RST);
      mcu.byte_op(1'h1, 1'h1, 1'h1, 8'h00, rv);
      chk("data_read", rv, 8'h40);
      mcu.byte_op(1'h1, 1'h1, 1'h0, 8'h00, rv);
      chk("status_read", rv, 8'hA5);
      chk("addr_step", addr, 8'h02);
      mcu.byte_op(1'h1, 1'h0, 1'h0, 8'h3C, rv);
      chk("cmd_write", {is_data, wr_byte[6:0]}, 8'h3C);
      chk("bus_idle", d_oe_n, MHI_OE_OFF);
      $display("parallel test %0d done", i);
    end
    for (int i = 0; i < 4; i++) begin
      fsync = i[0];
      @(negedge clock_i);
      chk("sync_out", {7'h0, tso}, {7'h0, i[0]});
    end
    ce = 1'h0;
    fsync = 1'h0;
    repeat (3) @(negedge clock_i);
    chk("ce_freeze", {7'h0, tso}, 8'h01);
    ce = 1'h1;
    repeat (2) @(negedge clock_i);
    chk("ce_resume", {7'h0, tso}, 8'h00);
    $display("sync test done");
    do_reset(MHI_STRAP_SER);
    mcu.ser_send(16'h005F, 8);
    mcu.ser_send({4'h0, 4'h8, 4'h0, 4'hD}, 16);
    repeat (20) @(negedge clock_i);
    chk("ser_byte", wr_byte, 8'h8D);
    chk("ser_is_data", {7'h0, is_data}, 8'h01);
    chk("ser_oe", d_oe_n, MHI_OE_SOD);
    mcu.ser_send({4'h0, 4'h2, 4'h0, 4'h1}, 16);
    repeat (20) @(negedge clock_i);
    chk("ser_next", wr_byte, 8'h21);
    chk("ser_count", 8'(n_wr), 8'h02);
    mcu.ser_send(16'h003F, 8);
    repeat (100) @(negedge clock_i);
    mcu.ser_read(rv);
    chk("ser_status", rv, 8'hA5);
    $display("serial test done");
    print_verdict;
  end
endmodule
